/* File: bench/flash_seq_properties.sv */
// concurrent property checker for the flash write command sequencer
`timescale 1ns/100ps
`default_nettype none

module flash_seq_properties
   import flash_seq_pkg::*;
(
   input wire logic                       sys_clk_i,
   input wire logic                       nrst_i,
   input wire logic                       reg_wr_i,
   input wire logic [3:0]                 reg_idx_i,
   input wire logic [15:0]                reg_wdata_i,
   input wire logic                       fetch_from_flash_i,
   input wire logic                       flash_done_i,
   input wire flash_seq_pkg::flash_cmd_t  flash_cmd_o,
   input wire logic [15:0]                control0_upper_o,
   input wire logic [31:0]                sector_mask_o,
   input wire logic                       busy_o,
   input wire logic                       erase_held_o,
   input wire logic                       temp_unprotect_bit_o,
   input wire logic                       wr_refused_o,
   input wire flash_seq_pkg::prot_state_t prot_state_o,
   input wire logic [15:0]                sector_protect_bits_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);

   start_launch_a: assert property ($rose(flash_cmd_o.valid) |->
      $past(reg_wr_i && reg_idx_i == 4'h0 && reg_wdata_i[15]))
      else $error("command raised without a start write");
   empty_start_a: assert property (
      reg_wr_i && reg_idx_i == 4'h0 && reg_wdata_i == 16'h8000 && !busy_o
      && (control0_upper_o & 16'h3900) == 16'h0000
      |=> wr_refused_o && !flash_cmd_o.valid)
      else $error("start without selection was not refused");
   cancel_select_a: assert property (
      reg_wr_i && reg_idx_i == 4'h0 && reg_wdata_i == 16'h0000 && !busy_o
      |=> (control0_upper_o & 16'h3900) == 16'h0000 || wr_refused_o)
      else $error("cleared selection still held");
   done_release_a: assert property (
      busy_o && flash_done_i |=> !busy_o && !flash_cmd_o.valid)
      else $error("command not released after done");
   cmd_hold_a: assert property (
      flash_cmd_o.valid && !flash_done_i |=> flash_cmd_o.valid
      && $stable(flash_cmd_o.addr) && $stable(flash_cmd_o.data))
      else $error("command changed while valid");
   dword_align_a: assert property (
      flash_cmd_o.valid && flash_cmd_o.kind == OP_DWORD
      |-> !flash_cmd_o.addr[2])
      else $error("double word address not aligned");
   erase_guard_a: assert property (
      $rose(flash_cmd_o.valid) && flash_cmd_o.kind == OP_ERASE
      |-> (flash_cmd_o.mask[15:0] & sector_protect_bits_o) == 16'h0000)
      else $error("erase mask covers a protected sector");
   temp_fetch_a: assert property (
      reg_wr_i && reg_idx_i == 4'h9 && reg_wdata_i[0] && !fetch_from_flash_i
      && !temp_unprotect_bit_o |=> !temp_unprotect_bit_o && wr_refused_o)
      else $error("temporary unprotect set outside flash fetch");
   suspend_request_start_a: assert property (
      reg_wr_i && reg_idx_i == 4'h0 && reg_wdata_i[15]
      && control0_upper_o[14] |=> wr_refused_o)
      else $error("start accepted with suspend held");
   // nonvolatile disable count bits only ever go from one to zero
   count_wear_a: assert property (
      (prot_state_o.disable_count & ~$past(prot_state_o.disable_count))
      == 16'h0000)
      else $error("disable field bit came back");
endmodule : flash_seq_properties

bind flash_write_command_sequencer flash_seq_properties u_props (
   .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr_i),
   .reg_idx_i(reg_idx_i), .reg_wdata_i(reg_wdata_i),
   .fetch_from_flash_i(fetch_from_flash_i), .flash_done_i(flash_done_i),
   .flash_cmd_o(flash_cmd_o), .control0_upper_o(control0_upper_o),
   .sector_mask_o(sector_mask_o), .busy_o(busy_o),
   .erase_held_o(erase_held_o), .temp_unprotect_bit_o(temp_unprotect_bit_o),
   .wr_refused_o(wr_refused_o), .prot_state_o(prot_state_o),
   .sector_protect_bits_o(sector_protect_bits_o));

`default_nettype wire

/* File: bench/testbench.sv */
// self-checking testbench for the flash write command sequencer
`timescale 1ns/100ps
`default_nettype none

module testbench;
   import flash_seq_pkg::*;

   logic        clk;
   logic        nrst;
   logic        reg_wr;
   logic [3:0]  idx;
   logic [15:0] wdata;
   logic        fetch;
   logic        done;
   flash_cmd_t  cmd;
   logic [15:0] ctrl;
   logic [31:0] smask;
   logic        busy;
   logic        held;
   logic        temp;
   logic        refused;
   prot_state_t prot;
   logic [15:0] prot_bits;
   logic        ref_seen;
   int          fails;
   int          num_checks;

   flash_write_command_sequencer DUT (
      .sys_clk_i(clk), .nrst_i(nrst), .reg_wr_i(reg_wr), .reg_idx_i(idx),
      .reg_wdata_i(wdata), .fetch_from_flash_i(fetch), .flash_done_i(done),
      .flash_cmd_o(cmd), .control0_upper_o(ctrl), .sector_mask_o(smask),
      .busy_o(busy), .erase_held_o(held), .temp_unprotect_bit_o(temp),
      .wr_refused_o(refused), .prot_state_o(prot),
      .sector_protect_bits_o(prot_bits));

   always #2 clk = ~clk;

   task automatic chk(input string n, input logic [63:0] s, e);
      num_checks++;
      if (s !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   // one idle cycle between writes keeps the strobe a clean pulse
   task automatic wr(input logic [3:0] i, input logic [15:0] d,
                     input logic f = 1'b0);
      idx = i;
      wdata = d;
      fetch = f;
      reg_wr = 1'b1;
      @(posedge clk); #1;
      // the refusal pulse stands only in the cycle after the write
      ref_seen = refused;
      reg_wr = 1'b0;
      @(posedge clk); #1;
   endtask : wr

   task automatic finish_op();
      done = 1'b1;
      @(posedge clk); #1;
      done = 1'b0;
      @(posedge clk); #1;
   endtask : finish_op

   task automatic load(input logic [15:0] sel, input logic [23:0] a,
                       input logic [63:0] d);
      wr(4'h0, sel);
      wr(4'h3, a[15:0]);
      wr(4'h4, {8'h00, a[23:16]});
      for (int k = 0; k < 4; k++) begin
         wr(4'(5 + k), d[16*k +: 16]);
      end
   endtask : load

   task automatic prot_set(input logic [23:0] a, input logic [63:0] d);
      load(16'h0100, a, d);
      wr(4'h0, 16'h8000);
      finish_op();
   endtask : prot_set

   task automatic t_program();
      chk("protected sectors", prot_bits, 16'h0000);
      load(16'h2000, 24'h025554, 64'hFFFF_FFFF_AAAA_AAAA);
      chk("word select", ctrl, 16'h2000);
      chk("valid before start", cmd.valid, 1'b0);
      wr(4'h0, 16'h8000);
      chk("word valid", cmd.valid, 1'b1);
      chk("word kind", cmd.kind, OP_WORD);
      chk("word addr", cmd.addr, 24'h025554);
      chk("word data", cmd.data[31:0], 32'hAAAA_AAAA);
      finish_op();
      chk("busy after done", busy, 1'b0);
      load(16'h1000, 24'h03555C, 64'hAA55_AA55_55AA_55AA);
      wr(4'h0, 16'h8000);
      chk("dword kind", cmd.kind, OP_DWORD);
      chk("dword addr", cmd.addr, 24'h035558);
      chk("dword data", cmd.data, 64'hAA55_AA55_55AA_55AA);
      finish_op();
   endtask : t_program

   task automatic t_cancel();
      wr(4'h0, 16'h2000);
      wr(4'h0, 16'h0000);
      chk("cancelled select", ctrl, 16'h0000);
      wr(4'h0, 16'h8000);
      chk("empty start refused", ref_seen, 1'b1);
      chk("no command", cmd.valid, 1'b0);
   endtask : t_cancel

   task automatic t_erase();
      wr(4'h0, 16'h0800);
      wr(4'h1, 16'h0003);
      wr(4'h0, 16'h8000);
      chk("erase kind", cmd.kind, OP_ERASE);
      chk("erase mask", cmd.mask, 32'h0000_0003);
      wr(4'h0, 16'h4800);
      chk("suspend request", cmd.suspend, 1'b1);
      finish_op();
      chk("erase held", held, 1'b1);
      chk("held select", ctrl, 16'h4800);
      wr(4'h0, 16'h8000);
      chk("start while suspended", ref_seen, 1'b1);
      wr(4'h0, 16'h0000);
      wr(4'h0, 16'h0800);
      wr(4'h0, 16'h8000);
      chk("erase resumed", cmd.valid, 1'b1);
      finish_op();
      chk("mask cleared", smask, 32'h0000_0000);
   endtask : t_erase

   task automatic t_protect();
      prot_set(24'h08DFB4, 64'hFFFF_FFFF_FFFF_FFF0);
      chk("nv sector protect", prot.sector_protect, 16'hFFF0);
      chk("protected sectors", prot_bits, 16'h000F);
      wr(4'h0, 16'h0800);
      wr(4'h1, 16'h001F);
      wr(4'h0, 16'h8000);
      chk("erase skips protected", cmd.mask[15:0], 16'h0010);
      finish_op();
      prot_set(24'h08DFB8, 64'hFFFF_FFFF_FFFF_FFFC);
      chk("access protected", prot.access_protected, 1'b1);
      wr(4'h0, 16'h2000);
      chk("locked write", ref_seen, 1'b1);
      wr(4'h9, 16'h0001, 1'b0);
      chk("unprotect from ram", temp, 1'b0);
      wr(4'h9, 16'h0001, 1'b1);
      chk("unprotect from flash", temp, 1'b1);
   endtask : t_protect

   task automatic t_cycles();
      logic [15:0] e;
      for (int i = 1; i <= 16; i++) begin
         e = 16'hFFFF << i;
         prot_set(24'h08DFBC, 64'hFFFF_FFFF_FFFF_FFFE);
         chk("disable field", prot.disable_count, e);
         chk("unprotected", prot.access_protected, 1'b0);
         prot_set(24'h08DFBC, 64'hFFFF_FFFF_FFFE_FFFF);
         chk("reenable field", prot.reenable_count, e);
         chk("protected again", prot.access_protected, 1'b1);
      end
      // a seventeenth attempt finds no bit left to clear
      prot_set(24'h08DFBC, 64'hFFFF_FFFF_FFFF_FFFE);
      chk("cycles exhausted", prot.access_protected, 1'b1);
      wr(4'h9, 16'h0000);
      chk("unprotect released", temp, 1'b0);
   endtask : t_cycles

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : stop_test

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      stop_test();
   end

   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      reg_wr = 1'b0;
      idx = 4'h0;
      wdata = 16'h0000;
      fetch = 1'b0;
      done = 1'b0;
      repeat (5) @(posedge clk);
      #1;
      nrst = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      t_program();
      t_cancel();
      t_erase();
      t_protect();
      t_cycles();
      stop_test();
   end
endmodule : testbench

`default_nettype wire

/* File: verilog/flash_seq_cfg.svh */
// constants of the flash write command sequencer
`ifndef FLASH_SEQ_CFG_SVH
`define FLASH_SEQ_CFG_SVH

// register indices on the 16-bit write port
`define REG_CTRL0_UPPER    4'h0
`define REG_MASK_LOW       4'h1
`define REG_MASK_HIGH      4'h2
`define REG_ADDR_LOW       4'h3
`define REG_ADDR_HIGH      4'h4
`define REG_DATA0_LOW      4'h5
`define REG_DATA0_HIGH     4'h6
`define REG_DATA1_LOW      4'h7
`define REG_DATA1_HIGH     4'h8
`define REG_TEMP_UNPROTECT 4'h9

// bit positions in control0_upper
`define BIT_START          15
`define BIT_SUSPEND        14
`define BIT_WORD_PROG      13
`define BIT_DWORD_PROG     12
`define BIT_SECTOR_ERASE   11
`define BIT_PROT_SET       8
`define SELECT_MASK        16'h3900

// nonvolatile protection locations
`define ADDR_SECTOR_PROT   24'h08DFB4
`define ADDR_ACCESS_PROT   24'h08DFB8
`define ADDR_PROT_CYCLES   24'h08DFBC

// reset value and double word address bit
`define NV_ERASED_16       16'hFFFF
`define DWORD_ADDR_BIT     2

`endif

/* File: verilog/flash_seq_pkg.sv */
// types shared by the flash write command sequencer
package flash_seq_pkg;

   typedef enum logic [2:0] {
      OP_NONE   = 3'b000,
      OP_WORD   = 3'b001,
      OP_DWORD  = 3'b010,
      OP_ERASE  = 3'b011,
      OP_PROT   = 3'b100
   } op_kind_t;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_RUN    = 2'b01,
      ST_HELD   = 2'b10
   } seq_state_t;

   typedef struct packed {
      logic        valid;
      logic        suspend;
      op_kind_t    kind;
      logic [23:0] addr;
      logic [63:0] data;
      logic [31:0] mask;
   } flash_cmd_t;

   typedef struct packed {
      logic [15:0] sector_protect;
      logic [15:0] access_enable;
      logic [15:0] disable_count;
      logic [15:0] reenable_count;
      logic        access_protected;
   } prot_state_t;

endpackage : flash_seq_pkg

/* File: verilog/flash_write_command_sequencer.sv */
// flash write command sequencer: select, load, start, suspend
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_cfg.svh"

module flash_write_command_sequencer (
   input  wire logic                       sys_clk_i,
   input  wire logic                       nrst_i,
   input  wire logic                       reg_wr_i,
   input  wire logic [3:0]                 reg_idx_i,
   input  wire logic [15:0]                reg_wdata_i,
   input  wire logic                       fetch_from_flash_i,
   input  wire logic                       flash_done_i,
   output var  flash_seq_pkg::flash_cmd_t  flash_cmd_o,
   output logic [15:0]                     control0_upper_o,
   output logic [31:0]                     sector_mask_o,
   output logic                            busy_o,
   output logic                            erase_held_o,
   output logic                            temp_unprotect_bit_o,
   output logic                            wr_refused_o,
   output var  flash_seq_pkg::prot_state_t prot_state_o,
   output logic [15:0]                     sector_protect_bits_o
);
   import flash_seq_pkg::*;

   logic        rst_meta_r;
   logic        rst_sync_n_r;

   seq_state_t  state_r,            state_nxt;
   logic [15:0] control0_upper_r,   control0_upper_nxt;
   logic [15:0] sector_mask_low_r,  sector_mask_low_nxt;
   logic [15:0] sector_mask_high_r, sector_mask_high_nxt;
   logic [15:0] target_addr_low_r,  target_addr_low_nxt;
   logic [15:0] target_addr_high_r, target_addr_high_nxt;
   logic [15:0] data0_low_r,        data0_low_nxt;
   logic [15:0] data0_high_r,       data0_high_nxt;
   logic [15:0] data1_low_r,        data1_low_nxt;
   logic [15:0] data1_high_r,       data1_high_nxt;
   logic        temp_unprotect_r,   temp_unprotect_nxt;
   logic        erase_held_r,       erase_held_nxt;
   flash_cmd_t  cmd_r,              cmd_nxt;
   logic        refused_r,          refused_nxt;
   logic        prot_wr_r,          prot_wr_nxt;
   logic        busy_r,             busy_nxt;

   logic [15:0] sel;
   logic        one_hot;
   op_kind_t    kind;
   logic        wr_ok;
   logic [15:0] eff_protect;
   prot_state_t prot_state;

   // reset enters asynchronously, released on the clock
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_meta_r   <= 1'b0;
         rst_sync_n_r <= 1'b0;
      end else begin
         rst_meta_r   <= 1'b1;
         rst_sync_n_r <= rst_meta_r;
      end
   end

   // start reuses the held selection plus any select bits in the write
   assign sel     = (control0_upper_r | reg_wdata_i) & `SELECT_MASK;
   assign one_hot = (sel != 16'h0000) && ((sel & (sel - 16'h0001)) == 16'h0);

   always_comb begin
      case (1'b1)
         sel[`BIT_WORD_PROG]:    kind = OP_WORD;
         sel[`BIT_DWORD_PROG]:   kind = OP_DWORD;
         sel[`BIT_SECTOR_ERASE]: kind = OP_ERASE;
         sel[`BIT_PROT_SET]:     kind = OP_PROT;
         default:                kind = OP_NONE;
      endcase
   end

   // registers other than the temp unprotect register stay locked while access protection holds and temp_unprotect_r is clear
   assign wr_ok = reg_wr_i &&
                  (!prot_state.access_protected || temp_unprotect_r);

   always_comb begin
      state_nxt            = state_r;
      control0_upper_nxt   = control0_upper_r;
      sector_mask_low_nxt  = sector_mask_low_r;
      sector_mask_high_nxt = sector_mask_high_r;
      target_addr_low_nxt  = target_addr_low_r;
      target_addr_high_nxt = target_addr_high_r;
      data0_low_nxt        = data0_low_r;
      data0_high_nxt       = data0_high_r;
      data1_low_nxt        = data1_low_r;
      data1_high_nxt       = data1_high_r;
      temp_unprotect_nxt   = temp_unprotect_r;
      erase_held_nxt       = erase_held_r;
      cmd_nxt              = cmd_r;
      refused_nxt          = 1'b0;
      prot_wr_nxt          = 1'b0;

      if (reg_wr_i && reg_idx_i == `REG_TEMP_UNPROTECT) begin
         // only code running from flash may lift access protection
         if (!reg_wdata_i[0] || fetch_from_flash_i) begin
            temp_unprotect_nxt = reg_wdata_i[0];
         end else begin
            refused_nxt = 1'b1;
         end
      end else if (reg_wr_i && !wr_ok) begin
         refused_nxt = 1'b1;
      end else if (wr_ok && state_r == ST_RUN) begin
         // suspend bit halts a running erase
         if (reg_idx_i == `REG_CTRL0_UPPER && reg_wdata_i[`BIT_SUSPEND] &&
             cmd_r.kind == OP_ERASE) begin
            control0_upper_nxt[`BIT_SUSPEND] = 1'b1;
            cmd_nxt.suspend                  = 1'b1;
         end else begin
            refused_nxt = 1'b1;
         end
      end else if (wr_ok) begin
         case (reg_idx_i)
            `REG_CTRL0_UPPER: begin
               if (!reg_wdata_i[`BIT_START]) begin
                  // selection step; clearing a bit cancels it
                  control0_upper_nxt = reg_wdata_i;
               end else if (!one_hot || control0_upper_r[`BIT_SUSPEND] ||
                            (erase_held_r && kind == OP_PROT)) begin
                  // no single selection, suspend still set, or protection set while an erase is held: refused
                  refused_nxt = 1'b1;
               end else begin
                  control0_upper_nxt = sel;
                  state_nxt          = ST_RUN;
                  cmd_nxt.valid      = 1'b1;
                  cmd_nxt.suspend    = 1'b0;
                  cmd_nxt.kind       = kind;
                  cmd_nxt.addr       = {target_addr_high_r[7:0],
                                        target_addr_low_r};
                  // word uses pair 0, double word both pairs
                  cmd_nxt.data       = {data1_high_r, data1_low_r,
                                        data0_high_r, data0_low_r};
                  if (kind == OP_DWORD) begin
                     cmd_nxt.addr[`DWORD_ADDR_BIT] = 1'b0;
                  end
                  // protected sectors drop out of the erase mask
                  cmd_nxt.mask = {sector_mask_high_r,
                                  sector_mask_low_r & ~eff_protect};
                  if (kind == OP_ERASE) begin
                     erase_held_nxt = 1'b0;
                  end
               end
            end
            `REG_MASK_LOW:   sector_mask_low_nxt  = reg_wdata_i;
            `REG_MASK_HIGH:  sector_mask_high_nxt = reg_wdata_i;
            `REG_ADDR_LOW:   target_addr_low_nxt  = reg_wdata_i;
            `REG_ADDR_HIGH:  target_addr_high_nxt = reg_wdata_i;
            `REG_DATA0_LOW:  data0_low_nxt        = reg_wdata_i;
            `REG_DATA0_HIGH: data0_high_nxt       = reg_wdata_i;
            `REG_DATA1_LOW:  data1_low_nxt        = reg_wdata_i;
            `REG_DATA1_HIGH: data1_high_nxt       = reg_wdata_i;
            default:         refused_nxt          = 1'b1;
         endcase
      end

      // completion beats any write in the same cycle
      if (state_r == ST_RUN && flash_done_i) begin
         cmd_nxt.valid      = 1'b0;
         control0_upper_nxt = 16'h0000;
         if (cmd_r.suspend) begin
            erase_held_nxt = 1'b1;
            state_nxt      = ST_HELD;
            control0_upper_nxt[`BIT_SUSPEND]      = 1'b1;
            control0_upper_nxt[`BIT_SECTOR_ERASE] = 1'b1;
         end else begin
            state_nxt = erase_held_r ? ST_HELD : ST_IDLE;
            if (cmd_r.kind == OP_ERASE) begin
               sector_mask_low_nxt  = 16'h0000;
               sector_mask_high_nxt = 16'h0000;
            end
            prot_wr_nxt = (cmd_r.kind == OP_PROT);
         end
      end

      // busy kept in its own flop so the output carries no decode
      busy_nxt = (state_nxt == ST_RUN);
   end

   always_ff @(posedge sys_clk_i or negedge rst_sync_n_r) begin
      if (!rst_sync_n_r) begin
         state_r            <= ST_IDLE;
         control0_upper_r   <= 16'h0000;
         sector_mask_low_r  <= 16'h0000;
         sector_mask_high_r <= 16'h0000;
         target_addr_low_r  <= 16'h0000;
         target_addr_high_r <= 16'h0000;
         data0_low_r        <= 16'h0000;
         data0_high_r       <= 16'h0000;
         data1_low_r        <= 16'h0000;
         data1_high_r       <= 16'h0000;
         temp_unprotect_r   <= 1'b0;
         erase_held_r       <= 1'b0;
         cmd_r              <= '0;
         refused_r          <= 1'b0;
         prot_wr_r          <= 1'b0;
         busy_r             <= 1'b0;
      end else begin
         state_r            <= state_nxt;
         control0_upper_r   <= control0_upper_nxt;
         sector_mask_low_r  <= sector_mask_low_nxt;
         sector_mask_high_r <= sector_mask_high_nxt;
         target_addr_low_r  <= target_addr_low_nxt;
         target_addr_high_r <= target_addr_high_nxt;
         data0_low_r        <= data0_low_nxt;
         data0_high_r       <= data0_high_nxt;
         data1_low_r        <= data1_low_nxt;
         data1_high_r       <= data1_high_nxt;
         temp_unprotect_r   <= temp_unprotect_nxt;
         erase_held_r       <= erase_held_nxt;
         cmd_r              <= cmd_nxt;
         refused_r          <= refused_nxt;
         prot_wr_r          <= prot_wr_nxt;
         busy_r             <= busy_nxt;
      end
   end

   // finished protection-set commits to the store
   nv_protect_store u_store (
      .clk_i            (sys_clk_i),
      .rst_n_i          (rst_sync_n_r),
      .wr_i             (prot_wr_r),
      .addr_i           (cmd_r.addr),
      .data_i           (cmd_r.data[31:0]),
      .temp_unprotect_i (temp_unprotect_r),
      .state_o          (prot_state),
      .eff_protect_o    (eff_protect)
   );

   assign flash_cmd_o           = cmd_r;
   assign control0_upper_o      = control0_upper_r;
   assign sector_mask_o         = {sector_mask_high_r, sector_mask_low_r};
   assign busy_o                = busy_r;
   assign erase_held_o          = erase_held_r;
   assign temp_unprotect_bit_o  = temp_unprotect_r;
   assign wr_refused_o          = refused_r;
   assign prot_state_o          = prot_state;
   assign sector_protect_bits_o = eff_protect;

endmodule : flash_write_command_sequencer
`default_nettype wire

/* File: verilog/nv_protect_store.sv */
// nonvolatile protection store written by protection-set operations
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_cfg.svh"

module nv_protect_store (
   input  wire logic                      clk_i,
   input  wire logic                      rst_n_i,
   input  wire logic                      wr_i,
   input  wire logic [23:0]               addr_i,
   input  wire logic [31:0]               data_i,
   input  wire logic                      temp_unprotect_i,
   output var  flash_seq_pkg::prot_state_t state_o,
   output logic [15:0]                    eff_protect_o
);
   import flash_seq_pkg::*;

   logic [15:0] nv_sector_protect_r, nv_sector_protect_nxt;
   logic [15:0] vol_unprot_r,        vol_unprot_nxt;
   logic [15:0] nv_access_protect_enable_r, nv_access_protect_enable_nxt;
   logic [15:0] nv_protect_disable_count_r, nv_protect_disable_count_nxt;
   logic [15:0] nv_protect_reenable_count_r;
   logic [15:0] nv_protect_reenable_count_nxt;
   logic        perm_disabled;

   // a disable consumed one bit more than the re-enables did
   assign perm_disabled = nv_protect_disable_count_r !=
                          nv_protect_reenable_count_r;

   always_comb begin
      nv_sector_protect_nxt        = nv_sector_protect_r;
      vol_unprot_nxt               = vol_unprot_r;
      nv_access_protect_enable_nxt = nv_access_protect_enable_r;
      nv_protect_disable_count_nxt = nv_protect_disable_count_r;
      nv_protect_reenable_count_nxt = nv_protect_reenable_count_r;
      if (wr_i) begin
         case (addr_i)
            `ADDR_SECTOR_PROT: begin
               // program zeros, ones only lift protection until reset
               nv_sector_protect_nxt = nv_sector_protect_r & data_i[15:0];
               vol_unprot_nxt        = data_i[15:0];
            end
            `ADDR_ACCESS_PROT: begin
               nv_access_protect_enable_nxt =
                  nv_access_protect_enable_r & data_i[15:0];
            end
            `ADDR_PROT_CYCLES: begin
               // each cycle clears the lowest remaining bit once
               if (temp_unprotect_i && !perm_disabled &&
                   (nv_protect_disable_count_r != 16'h0000) &&
                   (data_i[15:0] != `NV_ERASED_16)) begin
                  nv_protect_disable_count_nxt = nv_protect_disable_count_r &
                     (nv_protect_disable_count_r - 16'h0001);
               end else if (temp_unprotect_i && perm_disabled &&
                            (data_i[31:16] != `NV_ERASED_16)) begin
                  nv_protect_reenable_count_nxt = nv_protect_reenable_count_r
                     & (nv_protect_reenable_count_r - 16'h0001);
               end
            end
            default: begin
               nv_sector_protect_nxt = nv_sector_protect_r;
            end
         endcase
      end
   end

   // nonvolatile cells come up erased; the volatile lift clears at reset
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         nv_sector_protect_r         <= `NV_ERASED_16;
         vol_unprot_r                <= 16'h0000;
         nv_access_protect_enable_r  <= `NV_ERASED_16;
         nv_protect_disable_count_r  <= `NV_ERASED_16;
         nv_protect_reenable_count_r <= `NV_ERASED_16;
         // mirror the erased cells so the first edge shows no jump
         state_o.sector_protect      <= `NV_ERASED_16;
         state_o.access_enable       <= `NV_ERASED_16;
         state_o.disable_count       <= `NV_ERASED_16;
         state_o.reenable_count      <= `NV_ERASED_16;
         state_o.access_protected    <= 1'b0;
         eff_protect_o               <= 16'h0000;
      end else begin
         nv_sector_protect_r         <= nv_sector_protect_nxt;
         vol_unprot_r                <= vol_unprot_nxt;
         nv_access_protect_enable_r  <= nv_access_protect_enable_nxt;
         nv_protect_disable_count_r  <= nv_protect_disable_count_nxt;
         nv_protect_reenable_count_r <= nv_protect_reenable_count_nxt;
         state_o.sector_protect      <= nv_sector_protect_nxt;
         state_o.access_enable       <= nv_access_protect_enable_nxt;
         state_o.disable_count       <= nv_protect_disable_count_nxt;
         state_o.reenable_count      <= nv_protect_reenable_count_nxt;
         state_o.access_protected    <= !nv_access_protect_enable_nxt[0] &&
            (nv_protect_disable_count_nxt == nv_protect_reenable_count_nxt);
         // zero bit protects unless lifted temporarily
         eff_protect_o <= ~nv_sector_protect_nxt & ~vol_unprot_nxt;
      end
   end

endmodule : nv_protect_store
`default_nettype wire
